// ===== core/mmsb_regs.svh
// register indices, field positions, reset values and timing counts
`ifndef MMSB_REGS_SVH
`define MMSB_REGS_SVH

// register indices (byte address is four times the index)
`define MMSB_IDX_MAP        8'h10
`define MMSB_IDX_BANK0      8'h14
`define MMSB_IDX_BANK1      8'h15
`define MMSB_IDX_BANK2      8'h16
`define MMSB_IDX_BANK3      8'h17
`define MMSB_IDX_ECR        8'h18
`define MMSB_IDX_TIM        8'h19
`define MMSB_IDX_STAT       8'h1A

// mapping register fields
`define MMSB_MAP_ROOT_A16   0
`define MMSB_MAP_ROOT_A19   1
`define MMSB_MAP_DATA_A16   2
`define MMSB_MAP_DATA_A19   3
`define MMSB_MAP_FORCE_SEL  4
`define MMSB_MAP_SPLIT      5
`define MMSB_MAP_W          6

// expanded code register fields
`define MMSB_ECR_BANK_LO    0
`define MMSB_ECR_EN         2
`define MMSB_ECR_W          3

// timing register fields
`define MMSB_TIM_WE0        0
`define MMSB_TIM_WE1        1
`define MMSB_TIM_OE0        2
`define MMSB_TIM_OE1        3
`define MMSB_TIM_W          4

// bank control register fields
`define MMSB_BANK_CS_LO     0
`define MMSB_BANK_SET       2
`define MMSB_BANK_WINH      3
`define MMSB_BANK_INV18     4
`define MMSB_BANK_INV19     5
`define MMSB_BANK_WS_LO     6

// reset values
`define MMSB_MAP_RST        6'h00
`define MMSB_ECR_RST        3'h0
`define MMSB_TIM_RST        4'h0
`define MMSB_BANK_RST       8'h00

// access lengths in clocks before wait states, then wait states per bank register code
`define MMSB_RD_CLKS        4'h2
`define MMSB_WR_CLKS        4'h3
`define MMSB_WS_00          4'h4
`define MMSB_WS_01          4'h2
`define MMSB_WS_10          4'h1
`define MMSB_WS_11          4'h0

`endif

// ===== core/mmsb_pkg.sv
// types shared by the memory map and strobe timing block
package mmsb_pkg;

   // segment an access falls in
   typedef enum logic [1:0] {
      SEG_ROOT  = 2'b00,
      SEG_DATA  = 2'b01,
      SEG_STACK = 2'b10,
      SEG_XPC   = 2'b11
   } mmsb_seg_t;

   // memory cycle state
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_ACC  = 1'b1
   } mmsb_st_t;

   // access request from the core
   typedef struct packed {
      logic        req;
      logic        fetch;
      logic        write;
      logic [15:0] log_addr;
      logic [19:0] phys_addr;
      logic [7:0]  seg_size;
   } mmsb_req_t;

   // memory pins, active low
   typedef struct packed {
      logic [19:0] addr;
      logic        cs0_n;
      logic        chip_select_second_n;
      logic        cs2_n;
      logic        output_enable_bank_zero_n;
      logic        output_enable_bank_one_n;
      logic        write_enable_bank_zero_n;
      logic        write_enable_bank_one_n;
   } mmsb_mem_t;

   // rising edge state of the block
   typedef struct packed {
      mmsb_st_t         st;
      logic [3:0]       ph;
      logic [3:0]       len;
      logic             wr;
      logic             done;
      logic [19:0]      addr;
      logic [2:0]       cs;
      logic [1:0]       oe;
      logic [1:0]       we;
      logic [1:0]       bank;
      mmsb_seg_t        seg;
      logic [5:0]       map;
      logic [2:0]       ecr;
      logic [3:0]       tim;
      logic [3:0][7:0]  bank_reg;
      logic [31:0]      prdata;
   } mmsb_state_t;

   // falling edge state: early and lagging strobe copies
   typedef struct packed {
      logic [1:0] oe_early;
      logic [1:0] we_early;
      logic [1:0] we_lag;
   } mmsb_half_t;

endpackage : mmsb_pkg

// ===== core/mmsb_top.sv
// memory map inversion, bank selection and strobe timing with an apb register slave
`include "mmsb_regs.svh"

module mmsb_top
   import mmsb_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // clock, reset, enable
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              clk_en,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   // core access request
   input  wire mmsb_req_t         core_req,
   output logic                   core_busy,
   output logic                   core_done,
   // external memory pins
   output mmsb_mem_t              mem
);

   mmsb_state_t s_q;
   mmsb_state_t s_d;
   mmsb_half_t  h_q;
   mmsb_half_t  h_d;

   // register index of an apb byte address, all ones when misaligned
   // an all-ones index is unmapped, so a misaligned access answers with an error
   function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
      logic [7:0] idx;
      idx = 8'hFF;
      if (a[1:0] == 2'b00) begin
         idx = 8'(a >> 2);
      end
      return idx;
   endfunction : reg_index

   // true when the index names a mapped register
   function automatic logic reg_mapped(input logic [7:0] idx);
      logic hit;
      hit = 1'b0;
      case (idx)
         `MMSB_IDX_MAP, `MMSB_IDX_ECR, `MMSB_IDX_TIM, `MMSB_IDX_STAT: begin
            hit = 1'b1;
         end
         `MMSB_IDX_BANK0, `MMSB_IDX_BANK1, `MMSB_IDX_BANK2, `MMSB_IDX_BANK3: begin
            hit = 1'b1;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      return hit;
   endfunction : reg_mapped

   // wait states from a bank register's top two bits
   function automatic logic [3:0] wait_clks(input logic [1:0] ws);
      logic [3:0] n;
      case (ws)
         2'b00: begin
            n = `MMSB_WS_00;
         end
         2'b01: begin
            n = `MMSB_WS_01;
         end
         2'b10: begin
            n = `MMSB_WS_10;
         end
         default: begin
            n = `MMSB_WS_11;
         end
      endcase
      return n;
   endfunction : wait_clks

   // segment of a logical address given the boundary register
   function automatic mmsb_seg_t seg_of(input logic [15:0] la, input logic [7:0] sz);
      mmsb_seg_t sg;
      if (la[15:13] == 3'b111) begin
         sg = SEG_XPC;
      end else if (la[15:12] >= sz[7:4]) begin
         sg = SEG_STACK;
      end else if (la[15:12] >= sz[3:0]) begin
         sg = SEG_DATA;
      end else begin
         sg = SEG_ROOT;
      end
      return sg;
   endfunction : seg_of

   // access decode signals
   logic [7:0]  idx;
   logic        mapped;
   logic        apb_wr;
   mmsb_seg_t   seg;
   logic        inv_on;
   logic [19:0] pre_addr;
   logic [1:0]  bank;
   logic [7:0]  breg;
   logic        take;

   // apb handshake: zero wait, frozen while the enable is low
   assign idx     = reg_index(paddr);
   assign mapped  = reg_mapped(idx);
   assign pready  = clk_en;
   assign pslverr = psel & penable & ~mapped;
   assign prdata  = s_q.prdata;
   assign apb_wr  = clk_en & psel & penable & pwrite & mapped;

   // segment, id inversion and bank choice for a new access
   always_comb begin
      seg      = seg_of(core_req.log_addr, core_req.seg_size);
      inv_on   = ~s_q.map[`MMSB_MAP_SPLIT] | ~core_req.fetch;
      pre_addr = core_req.phys_addr;
      if (inv_on && seg == SEG_ROOT) begin
         pre_addr[19] = pre_addr[19] ^ s_q.map[`MMSB_MAP_ROOT_A19];
         pre_addr[16] = pre_addr[16] ^ s_q.map[`MMSB_MAP_ROOT_A16];
      end
      if (inv_on && seg == SEG_DATA) begin
         pre_addr[19] = pre_addr[19] ^ s_q.map[`MMSB_MAP_DATA_A19];
         pre_addr[16] = pre_addr[16] ^ s_q.map[`MMSB_MAP_DATA_A16];
      end
      // the id inversion has already moved A19, so it steers the bank choice
      if (seg == SEG_XPC && s_q.ecr[`MMSB_ECR_EN]) begin
         bank = s_q.ecr[`MMSB_ECR_BANK_LO +: 2];
      end else begin
         bank = pre_addr[19:18];
      end
      breg = s_q.bank_reg[bank];
      take = clk_en & core_req.req & (s_q.st == ST_IDLE);
   end

   // next state: registers, memory cycle sequence and strobes
   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      // register writes
      if (apb_wr) begin
         case (idx)
            `MMSB_IDX_MAP: begin
               s_d.map = pwdata[`MMSB_MAP_W-1:0];
            end
            `MMSB_IDX_ECR: begin
               s_d.ecr = pwdata[`MMSB_ECR_W-1:0];
            end
            `MMSB_IDX_TIM: begin
               s_d.tim = pwdata[`MMSB_TIM_W-1:0];
            end
            `MMSB_IDX_BANK0: begin
               s_d.bank_reg[0] = pwdata[7:0];
            end
            `MMSB_IDX_BANK1: begin
               s_d.bank_reg[1] = pwdata[7:0];
            end
            `MMSB_IDX_BANK2: begin
               s_d.bank_reg[2] = pwdata[7:0];
            end
            `MMSB_IDX_BANK3: begin
               s_d.bank_reg[3] = pwdata[7:0];
            end
            default: begin
            end
         endcase
      end

      // read data is captured in the setup cycle
      if (clk_en && psel && !penable) begin
         case (idx)
            `MMSB_IDX_MAP: begin
               s_d.prdata = {26'h0, s_q.map};
            end
            `MMSB_IDX_ECR: begin
               s_d.prdata = {29'h0, s_q.ecr};
            end
            `MMSB_IDX_TIM: begin
               s_d.prdata = {28'h0, s_q.tim};
            end
            `MMSB_IDX_STAT: begin
               s_d.prdata = {27'h0, s_q.seg, s_q.bank, s_q.st == ST_ACC};
            end
            // bank control registers are write-only and read as zero
            default: begin
               s_d.prdata = 32'h0;
            end
         endcase
      end

      // memory cycle sequence
      case (s_q.st)
         ST_IDLE: begin
            if (take) begin
               s_d.st   = ST_ACC;
               s_d.ph   = 4'h0;
               s_d.wr   = core_req.write;
               s_d.bank = bank;
               s_d.seg  = seg;
               s_d.len  = (core_req.write ? `MMSB_WR_CLKS : `MMSB_RD_CLKS)
                          + wait_clks(breg[`MMSB_BANK_WS_LO +: 2]);
               // bank inversion comes after the bank choice
               s_d.addr     = pre_addr;
               s_d.addr[19] = pre_addr[19] ^ breg[`MMSB_BANK_INV19];
               s_d.addr[18] = pre_addr[18] ^ breg[`MMSB_BANK_INV18];
               s_d.cs       = 3'h0;
               case (breg[`MMSB_BANK_CS_LO +: 2])
                  2'b00: begin
                     s_d.cs[0] = 1'b1;
                  end
                  2'b01: begin
                     s_d.cs[1] = 1'b1;
                  end
                  default: begin
                     s_d.cs[2] = 1'b1;
                  end
               endcase
            end
         end
         ST_ACC: begin
            // the cycle ends once the phase reaches the length taken at the start
            if (clk_en) begin
               s_d.ph = s_q.ph + 4'h1;
               if (s_d.ph == s_q.len) begin
                  s_d.st   = ST_IDLE;
                  s_d.done = 1'b1;
                  s_d.cs   = 3'h0;
               end
            end
         end
         default: begin
            s_d.st = ST_IDLE;
         end
      endcase

      // output enable from the second clock to the end of a read
      s_d.oe = 2'b00;
      s_d.we = 2'b00;
      if (s_d.st == ST_ACC && s_d.ph != 4'h0) begin
         if (!s_d.wr) begin
            s_d.oe[s_q.bank_reg[s_d.bank][`MMSB_BANK_SET]] = 1'b1;
         end else if (!s_q.bank_reg[s_d.bank][`MMSB_BANK_WINH]
                      && s_d.ph <= s_d.len - 4'h2) begin
            s_d.we[s_q.bank_reg[s_d.bank][`MMSB_BANK_SET]] = 1'b1;
         end
      end
      // a low enable discards every change above and holds the whole state
      if (!clk_en) begin
         s_d = s_q;
      end
   end

   // falling edge copies: early strobes look ahead, the lag holds write a half clock
   // these copies freeze with the enable too, so a stalled strobe keeps its shape
   always_comb begin
      h_d = h_q;
      if (clk_en) begin
         h_d.oe_early = s_d.oe;
         h_d.we_early = s_d.we;
         h_d.we_lag   = s_q.we;
      end
   end

   // rising edge state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q          <= '0;
         s_q.st       <= ST_IDLE;
         s_q.seg      <= SEG_ROOT;
         s_q.map      <= `MMSB_MAP_RST;
         s_q.ecr      <= `MMSB_ECR_RST;
         s_q.tim      <= `MMSB_TIM_RST;
         s_q.bank_reg <= {4{`MMSB_BANK_RST}};
      end else begin
         s_q <= s_d;
      end
   end

   // falling edge state
   always_ff @(negedge pclk or negedge presetn) begin
      if (!presetn) begin
         h_q <= '0;
      end else begin
         h_q <= h_d;
      end
   end

   // strobe shaping per bank set
   // extended write uses falling edge flops only, so it never moves at a rise
   logic [1:0] oe_on;
   logic [1:0] we_on;
   always_comb begin
      oe_on[0] = s_q.oe[0] | (s_q.tim[`MMSB_TIM_OE0] & h_q.oe_early[0]);
      oe_on[1] = s_q.oe[1] | (s_q.tim[`MMSB_TIM_OE1] & h_q.oe_early[1]);
      we_on[0] = h_q.we_lag[0] |
                 (s_q.tim[`MMSB_TIM_WE0] ? h_q.we_early[0] : s_q.we[0]);
      we_on[1] = h_q.we_lag[1] |
                 (s_q.tim[`MMSB_TIM_WE1] ? h_q.we_early[1] : s_q.we[1]);
   end

   // memory pins, active low; the second select may be held on
   always_comb begin
      mem.addr                      = s_q.addr;
      mem.cs0_n                     = ~s_q.cs[0];
      mem.chip_select_second_n      = ~(s_q.cs[1] | s_q.map[`MMSB_MAP_FORCE_SEL]);
      mem.cs2_n                     = ~s_q.cs[2];
      mem.output_enable_bank_zero_n = ~oe_on[0];
      mem.output_enable_bank_one_n  = ~oe_on[1];
      mem.write_enable_bank_zero_n  = ~we_on[0];
      mem.write_enable_bank_one_n   = ~we_on[1];
   end

   // core status
   assign core_busy = (s_q.st == ST_ACC);
   assign core_done = s_q.done;

endmodule : mmsb_top

// ===== verif/mmsb_chk_sva.sv
// concurrent checks on the ports of the memory map block
module mmsb_chk
   import mmsb_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic              pclk,
   input wire logic              presetn,
   // apb side
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic              pready,
   input wire logic [31:0]       prdata,
   input wire logic              pslverr,
   // access and pins
   input wire logic              core_busy,
   input wire mmsb_mem_t         mem
);
   logic [5:0] map_q;
   logic [3:0] tim_q;
   logic       we0_q;
   logic       oe0_q;
   logic       wr_ok;
   logic       rd_ok;
   // completed apb transfers
   assign wr_ok = psel & penable & pwrite & pready & ~pslverr;
   assign rd_ok = psel & penable & ~pwrite & pready;
   // shadow registers and the write strobe seen just before each rise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         map_q <= 6'h00;
         tim_q <= 4'h0;
         we0_q <= 1'b1;
      end else begin
         we0_q <= mem.write_enable_bank_zero_n;
         if (wr_ok && paddr == 8'h40) map_q <= pwdata[5:0];
         if (wr_ok && paddr == 8'h64) tim_q <= pwdata[3:0];
      end
   end
   // output enable seen just before each fall
   always_ff @(negedge pclk or negedge presetn) begin
      if (!presetn) oe0_q <= 1'b1;
      else oe0_q <= mem.output_enable_bank_zero_n;
   end
   property p_map_top;
      @(posedge pclk) disable iff (!presetn) rd_ok && paddr == 8'h40 |-> prdata[31:6] == 26'h0;
   endproperty
   a_map_top: assert property (p_map_top) else $error("map top bits not zero");
   property p_map_rd;
      @(posedge pclk) disable iff (!presetn) rd_ok && paddr == 8'h40 |-> prdata[5:0] == map_q;
   endproperty
   a_map_rd: assert property (p_map_rd) else $error("map readback differs");
   property p_map_ok;
      @(posedge pclk) disable iff (!presetn) psel && penable && paddr == 8'h40 |-> !pslverr;
   endproperty
   a_map_ok: assert property (p_map_ok) else $error("map address refused");
   property p_ecr_top;
      @(posedge pclk) disable iff (!presetn) rd_ok && paddr == 8'h60 |-> prdata[31:3] == 29'h0;
   endproperty
   a_ecr_top: assert property (p_ecr_top) else $error("ecr top bits not zero");
   property p_force;
      @(posedge pclk) disable iff (!presetn)
         map_q[4] && $past(map_q[4], 2) |-> !mem.chip_select_second_n;
   endproperty
   a_force: assert property (p_force) else $error("second select not forced");
   property p_one_cs;
      @(posedge pclk) disable iff (!presetn) !map_q[4] && !$past(map_q[4], 2)
         |-> $onehot0(~{mem.cs0_n, mem.chip_select_second_n, mem.cs2_n});
   endproperty
   a_one_cs: assert property (p_one_cs) else $error("several selects low");
   property p_idle;
      @(posedge pclk) disable iff (!presetn) !core_busy && !$past(core_busy)
         |-> &{mem.output_enable_bank_zero_n, mem.output_enable_bank_one_n,
               mem.write_enable_bank_zero_n, mem.write_enable_bank_one_n};
   endproperty
   a_idle: assert property (p_idle) else $error("strobe low while idle");
   property p_oe_norm;
      @(posedge pclk) disable iff (!presetn)
         !tim_q[2] |-> mem.output_enable_bank_zero_n == oe0_q;
   endproperty
   a_oe_norm: assert property (p_oe_norm) else $error("oe0 moved at fall");
   property p_we_ext;
      @(negedge pclk) disable iff (!presetn) tim_q[0] |-> mem.write_enable_bank_zero_n == we0_q;
   endproperty
   a_we_ext: assert property (p_we_ext) else $error("we0 moved at rise");
   property p_we_norm;
      @(negedge pclk) disable iff (!presetn)
         !tim_q[0] && $fell(mem.write_enable_bank_zero_n) |-> we0_q;
   endproperty
   a_we_norm: assert property (p_we_norm) else $error("we0 began at fall");
endmodule : mmsb_chk

bind mmsb_top mmsb_chk #(.ADDR_W(ADDR_W)) chk_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .core_busy(core_busy), .mem(mem)
);

// ===== verif/mmsb_mem_model.sv
// external memory stand-in: records the pins seen during one access
module mmsb_mem_model
   import mmsb_pkg::*;
(
   // clock and clear
   input  wire logic      pclk,
   input  wire logic      clr,
   // memory pins
   input  wire mmsb_mem_t mem,
   // what the last access showed
   output logic [19:0]    addr_q,
   output logic [2:0]     cs_q,
   output logic [11:0]    len_q,
   output logic [3:0]     start_q
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] lo;
   // sample mid half period, away from both edges; count low halves per strobe
   always @(pclk) begin
      #5;
      lo = ~{mem.output_enable_bank_one_n, mem.output_enable_bank_zero_n,
             mem.write_enable_bank_one_n, mem.write_enable_bank_zero_n};
      if (clr) begin
         cs_q = 3'h0;
         len_q = 12'h000;
         start_q = 4'h0;
      end else if (lo != 4'h0) begin
         addr_q = mem.addr;
         cs_q = cs_q | ~{mem.cs2_n, mem.chip_select_second_n, mem.cs0_n};
         for (int k = 0; k < 4; k++) begin
            if (lo[k] && len_q[3*k+:3] == 3'h0) start_q[k] = pclk; // high: began at rise
            if (lo[k]) len_q[3*k+:3] = len_q[3*k+:3] + 3'h1;
         end
      end
   end
endmodule : mmsb_mem_model

// ===== verif/tb.sv
// testbench for the memory map and strobe timing block
`include "mmsb_regs.svh"
module tb
   import mmsb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // map, ecr, fetch, segment, phys nibble, expected nibble, expected selects
   typedef struct packed {
      logic [5:0] map;
      logic [2:0] ecr;
      logic       f;
      logic [1:0] seg;
      logic [3:0] pn;
      logic [3:0] en;
      logic [2:0] ecs;
   } mmsb_tv_t;
   localparam logic [7:0] A_MAP = 8'(`MMSB_IDX_MAP * 4);
   localparam logic [7:0] A_B0  = 8'(`MMSB_IDX_BANK0 * 4);
   localparam logic [7:0] A_ECR = 8'(`MMSB_IDX_ECR * 4);
   localparam logic [7:0] A_TIM = 8'(`MMSB_IDX_TIM * 4);
   localparam logic [7:0] A_ST  = 8'(`MMSB_IDX_STAT * 4);
   localparam logic [7:0] BK [4] = '{8'hC0, 8'hE1, 8'hC2, 8'hC6};
   localparam mmsb_tv_t TV [13] = '{
      {6'h01, 3'h0, 1'b0, 2'h0, 4'h0, 4'h1, 3'h1},
      {6'h02, 3'h0, 1'b0, 2'h0, 4'h0, 4'h8, 3'h4},
      {6'h04, 3'h0, 1'b0, 2'h1, 4'h0, 4'h1, 3'h1},
      {6'h08, 3'h0, 1'b0, 2'h1, 4'h0, 4'h8, 3'h4},
      {6'h08, 3'h0, 1'b0, 2'h0, 4'h0, 4'h0, 3'h1},
      {6'h22, 3'h0, 1'b1, 2'h0, 4'h0, 4'h0, 3'h1},
      {6'h22, 3'h0, 1'b0, 2'h0, 4'h0, 4'h8, 3'h4},
      {6'h02, 3'h0, 1'b1, 2'h0, 4'h0, 4'h8, 3'h4},
      {6'h00, 3'h0, 1'b0, 2'h0, 4'h4, 4'hC, 3'h2},
      {6'h00, 3'h4, 1'b0, 2'h3, 4'hC, 4'hC, 3'h1},
      {6'h00, 3'h7, 1'b0, 2'h3, 4'h0, 4'h0, 3'h4},
      {6'h00, 3'h3, 1'b0, 2'h3, 4'h0, 4'h0, 3'h1},
      {6'h10, 3'h0, 1'b0, 2'h0, 4'h0, 4'h0, 3'h3}}; // second select bank unused
   logic        pclk = 1'b0;
   logic        presetn, clk_en, psel, penable, pwrite, pready, pslverr, core_busy, core_done;
   logic        clr, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic [19:0] m_addr;
   logic [2:0]  m_cs;
   logic [11:0] m_len, el;
   logic [3:0]  m_start, es;
   mmsb_req_t   core_req;
   mmsb_mem_t   mem;
   int          fails = 0, n_checks = 0, cyc = 0, k;
   mmsb_top #(.ADDR_W(8)) dut_u (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .core_req(core_req), .core_busy(core_busy),
      .core_done(core_done), .mem(mem));
   mmsb_mem_model mem_u (
      .pclk(pclk), .clr(clr), .mem(mem), .addr_q(m_addr), .cs_q(m_cs),
      .len_q(m_len), .start_q(m_start));
   // clock and cycle ceiling
   always #10 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc > 20000) begin
         fails++;
         summarize();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      n_checks++;
      if (g !== x) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, g, x);
      end
   endtask : chk
   // one apb transfer: setup, then access until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(r, x);
   endtask : rd
   // one core access, request held for one clock, then wait for done
   task automatic acc(input logic w, input logic f, input logic [15:0] la,
                      input logic [19:0] pa);
      @(posedge pclk);
      clr <= 1'b1;
      core_req <= '{req: 1'b1, fetch: f, write: w, log_addr: la, phys_addr: pa,
                    seg_size: 8'hD4};
      @(posedge pclk);
      clr <= 1'b0;
      core_req.req <= 1'b0;
      do begin
         @(posedge pclk);
      end while (core_done !== 1'b1);
      @(posedge pclk);
   endtask : acc
   task summarize();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize
   // main sequence
   initial begin
      {presetn, psel, penable, pwrite, clr} = 5'h00;
      clk_en = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h0;
      core_req = '0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(A_MAP, 32'h0);
      rd(A_ECR, 32'h0);
      rd(A_TIM, 32'h0);
      $display("test reset values done");
      apb(1'b1, A_MAP, 32'hFFFFFFFF);
      rd(A_MAP, 32'h3F);
      apb(1'b1, A_ECR, 32'hFF);
      rd(A_ECR, 32'h7);
      apb(1'b1, A_TIM, 32'hF); // upper nibble left clear
      rd(A_TIM, 32'hF);
      apb(1'b0, 8'h70, 32'h0);
      chk(32'(e), 32'h1);
      for (int i = 0; i < 4; i++) apb(1'b1, A_B0 + 8'(4 * i), 32'(BK[i]));
      rd(A_B0, 32'h0);
      $display("test registers done");
      apb(1'b1, A_TIM, 32'h0);
      for (int i = 0; i < 13; i++) begin
         apb(1'b1, A_MAP, 32'(TV[i].map));
         apb(1'b1, A_ECR, 32'(TV[i].ecr));
         acc(1'b0, TV[i].f, TV[i].seg == 2'h0 ? 16'h1000 : TV[i].seg == 2'h1 ? 16'h5000 :
             16'hE000, {TV[i].pn, 16'h1234});
         chk(32'(m_addr), 32'({TV[i].en, 16'h1234}));
         chk(32'(m_cs), 32'(TV[i].ecs));
      end
      chk(32'(mem.chip_select_second_n), 32'h0);
      apb(1'b1, A_MAP, 32'h0);
      repeat (3) @(posedge pclk);
      chk(32'(mem.chip_select_second_n), 32'h1);
      $display("test mapping done");
      for (int m = 0; m < 2; m++) for (int w = 0; w < 2; w++) for (int s = 0; s < 2; s++) begin
         k = (w != 0 ? 0 : 2) + s;
         el = 12'h000;
         el[3*k+:3] = w != 0 ? (m != 0 ? 3'h4 : 3'h3) : (m != 0 ? 3'h3 : 3'h2);
         es = 4'h0;
         es[k] = (m == 0);
         apb(1'b1, A_TIM, m != 0 ? 32'hF : 32'h0);
         acc(w[0], 1'b0, 16'h1000, s != 0 ? 20'hC1234 : 20'h01234);
         chk(32'(m_len), 32'(el));
         chk(32'(m_start), 32'(es));
      end
      rd(A_ST, 32'h6); // last access: root segment, bank three, idle
      $display("test strobe timing done");
      summarize();
   end
endmodule : tb
